// File: core/ircu_rshift.sv
`timescale 1ns/1ns
module ircu_rshift (
    // Significand in
    input wire logic [63:0] sig,
    input wire logic [15:0] shamt,
    // Integer part and rounding bits
    output logic [63:0] int_part,
    output logic guard,
    output logic sticky
);
    logic [127:0] wide;

    always_comb begin
        wide = {sig, 64'h0000_0000_0000_0000} >> shamt[6:0];
        if (shamt > 16'h0040) begin
            int_part = 64'h0000_0000_0000_0000;
            guard = 1'b0;
            sticky = |sig;
        end else begin
            int_part = wide[127:64];
            guard = wide[63];
            sticky = |wide[62:0];
        end
    end
endmodule : ircu_rshift

// File: core/ircu_top.sv
`timescale 1ns/1ns
module ircu_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Issue request and arithmetic controls
    input ircu_pkg::ircu_req_s req,
    input ircu_pkg::ircu_ctrl_s ctrl,
    // Register file write-back
    output ircu_pkg::ircu_res_s res
);
    import ircu_pkg::*;

    typedef struct packed {
        ircu_res_s res;
        logic ovf_det;
        logic inx_det;
    } ircu_state_s;

    ircu_state_s st_q;
    ircu_state_s st_d;

    function automatic logic [6:0] lead_zeros(logic [63:0] v);
        logic [6:0] n;
        n = 7'h40;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                n = 7'(63 - i);
            end
        end
        return n;
    endfunction : lead_zeros

    // Operation class
    logic is_i2r;
    logic is_long;
    logic is_trunc;
    logic bad_pair;

    // Integer-to-real path
    logic [63:0] i_src;
    logic i_neg;
    logic [63:0] i_mag;
    logic [6:0] i_lz;
    logic [63:0] i_norm;
    logic [14:0] i_exp;
    logic i_g;
    logic i_st;
    logic [24:0] i_sum;
    logic [63:0] i_sig;
    logic [14:0] i_exp_r;
    logic i_inx;

    // Real-to-integer path
    logic r_neg;
    logic [14:0] r_exp;
    logic [63:0] r_sig;
    logic r_big;
    logic [15:0] r_sh;
    logic [63:0] r_int;
    logic r_g;
    logic r_st;
    ircu_rmode_e r_mode;
    logic r_inc;
    logic [64:0] r_mag;
    logic [63:0] lim_pos;
    logic [63:0] lim_neg;
    logic r_ovf;
    logic [63:0] r_val;

    // Unpack the real operand ahead of the shifter
    always_comb begin
        r_neg = req.real_src[79];
        r_exp = req.real_src[78:64];
        r_sig = req.real_src[63:0];
        r_big = r_exp > EXP_INT_TOP;
        r_sh = r_big ? 16'h0000 : {1'b0, EXP_INT_TOP - r_exp};
    end

    ircu_rshift u_rshift (
        .sig(r_sig),
        .shamt(r_sh),
        .int_part(r_int),
        .guard(r_g),
        .sticky(r_st)
    );

    always_comb begin
        is_i2r = (req.op == OP_I2R) || (req.op == OP_IL2R);
        is_long = (req.op == OP_IL2R) || (req.op == OP_R2IL) || (req.op == OP_RZ2IL);
        is_trunc = (req.op == OP_RZ2I) || (req.op == OP_RZ2IL);
        // Long operands need an even lower register
        bad_pair = is_long && (is_i2r ? req.src_idx[0] : req.dst_idx[0]);

        // Short source sign-extends the low word, long source is the pair
        i_src = (req.op == OP_IL2R) ? req.int_src
                : {{32{req.int_src[31]}}, req.int_src[31:0]};
        i_neg = i_src[63];
        i_mag = i_neg ? (64'h0000_0000_0000_0000 - i_src) : i_src;
        i_lz = lead_zeros(i_mag);
        i_norm = i_mag << i_lz[5:0];
        i_exp = (i_mag == 64'h0000_0000_0000_0000) ? EXP_ZERO
                : (EXP_INT_TOP - {8'h00, i_lz});
        // Single target keeps 24 significant bits
        i_g = i_norm[SIG_W - SGL_KEEP - 1];
        i_st = |i_norm[SIG_W - SGL_KEEP - 2:0];
        i_sum = {1'b0, i_norm[63:40]}
                + {24'h00_0000, ircu_round_inc(ctrl.rmode, i_neg, i_norm[40], i_g, i_st)};
        i_sig = i_norm;
        i_exp_r = i_exp;
        i_inx = 1'b0;
        if (req.tgt_single) begin
            i_inx = i_g | i_st;
            if (i_sum[24]) begin
                i_sig = {1'b1, 63'h0};
                i_exp_r = i_exp + 15'h0001;
            end else begin
                i_sig = {i_sum[23:0], 40'h00_0000_0000};
            end
        end

        r_mode = is_trunc ? RM_ZERO : ctrl.rmode;
        r_inc = ircu_round_inc(r_mode, r_neg, r_int[0], r_g, r_st);
        r_mag = {1'b0, r_int} + {64'h0000_0000_0000_0000, r_inc};
        lim_pos = is_long ? LIM_POS_64 : LIM_POS_32;
        lim_neg = is_long ? LIM_NEG_64 : LIM_NEG_32;
        r_ovf = r_big || (r_mag > {1'b0, r_neg ? lim_neg : lim_pos});
        if (r_ovf) begin
            r_val = r_neg ? (64'h0000_0000_0000_0000 - lim_neg) : lim_pos;
        end else begin
            r_val = r_neg ? (64'h0000_0000_0000_0000 - r_mag[63:0]) : r_mag[63:0];
        end

        st_d = '0;
        if (req.valid) begin
            st_d.res.valid = 1'b1;
            if (bad_pair) begin
                st_d.res.pair_fault = 1'b1;
            end else if (is_i2r) begin
                st_d.res.fwe = 1'b1;
                st_d.res.freg_idx = req.dst_idx;
                st_d.res.freg_data = {i_neg, i_exp_r, i_sig};
                st_d.inx_det = i_inx;
                st_d.res.exc_inexact = i_inx & ~ctrl.mask_inexact;
            end else begin
                st_d.res.gwe_lo = 1'b1;
                st_d.res.gwe_hi = is_long;
                st_d.res.greg_idx = req.dst_idx;
                st_d.res.greg_lo = r_val[31:0];
                st_d.res.greg_hi = is_long ? r_val[63:32] : 32'h0000_0000;
                st_d.ovf_det = r_ovf;
                st_d.inx_det = ~r_ovf & (r_g | r_st);
                st_d.res.exc_int_ovf = r_ovf & ~ctrl.mask_int_ovf;
                st_d.res.exc_inexact = ~r_ovf & (r_g | r_st) & ~ctrl.mask_inexact;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign res = st_q.res;

    AST_I2R_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && is_i2r && !bad_pair |=> res.fwe && !res.gwe_lo
            && res.freg_idx == $past(req.dst_idx))
        else $error("integer-to-real did not write the float register");

    AST_PAIR_ODD: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_IL2R && req.src_idx[0]
            |=> res.pair_fault && !res.fwe && !res.exc_inexact)
        else $error("odd long source not refused");

    AST_INX_WIDE: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && is_i2r && !req.tgt_single |=> !st_q.inx_det && !res.exc_inexact)
        else $error("inexact on wide integer-to-real");

    AST_MASK: assert property (@(posedge core_clk) disable iff (!rst_b)
        res.exc_int_ovf || res.exc_inexact |-> (res.exc_int_ovf && !$past(ctrl.mask_int_ovf))
            || (res.exc_inexact && !$past(ctrl.mask_inexact)))
        else $error("masked exception raised");

    AST_R2I_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && !is_i2r && !bad_pair |=> res.gwe_lo && !res.fwe)
        else $error("real-to-integer did not write the general register");

    AST_PAIR_DST: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && is_long && !is_i2r |=> res.gwe_hi == !$past(req.dst_idx[0])
            && res.pair_fault == $past(req.dst_idx[0]))
        else $error("long destination pair handling wrong");

    AST_ROUND_UP: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_R2I && ctrl.rmode == RM_UP && !req.real_src[79]
            && req.real_src[78:64] == EXP_BIAS - 15'h0001 && req.real_src[63]
            |=> res.greg_lo == 32'h0000_0001)
        else $error("round up of a half did not give one");

    AST_TRUNC: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_RZ2I && !req.real_src[79]
            && req.real_src[78:64] == EXP_BIAS && req.real_src[63]
            |=> res.greg_lo == 32'h0000_0001 && !res.exc_int_ovf)
        else $error("truncation not toward zero");

    AST_OVF_BIG: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && !is_i2r && !bad_pair && req.real_src[78:64] > EXP_INT_TOP
            |=> st_q.ovf_det && res.exc_int_ovf == !$past(ctrl.mask_int_ovf)
            ##1 !st_q.ovf_det || $past(req.valid, 1))
        else $error("overflow not detected");

    AST_SAT_32: assert property (@(posedge core_clk) disable iff (!rst_b)
        res.gwe_lo && !res.gwe_hi && st_q.ovf_det
            |-> res.greg_lo == ($past(req.real_src[79]) ? 32'h8000_0000 : 32'h7FFF_FFFF))
        else $error("short overflow not saturated");

    AST_SHORT_HI: assert property (@(posedge core_clk) disable iff (!rst_b)
        res.gwe_lo && !res.gwe_hi |-> res.greg_hi == 32'h0000_0000)
        else $error("short result wrote high word");

    COV_I2R_SINGLE: cover property (@(posedge core_clk) disable iff (!rst_b)
        res.fwe && st_q.inx_det);
    COV_R2IL: cover property (@(posedge core_clk) disable iff (!rst_b)
        res.gwe_hi && !st_q.ovf_det);
    COV_OVF: cover property (@(posedge core_clk) disable iff (!rst_b)
        res.exc_int_ovf);
    COV_PAIR: cover property (@(posedge core_clk) disable iff (!rst_b)
        res.pair_fault);
endmodule : ircu_top

// File: include/ircu_pkg.sv
package ircu_pkg;

    localparam int unsigned EXP_W = 15;
    localparam int unsigned SIG_W = 64;
    localparam int unsigned XR_W = 80;
    localparam logic [14:0] EXP_BIAS = 15'h3FFF;
    localparam logic [14:0] EXP_SPECIAL = 15'h7FFF;
    // Exponent of a value whose integer bit sits at 2^63
    localparam logic [14:0] EXP_INT_TOP = 15'h403E;
    localparam logic [14:0] EXP_ZERO = 15'h0000;
    localparam int unsigned SGL_KEEP = 24;
    localparam logic [63:0] LIM_POS_32 = 64'h0000_0000_7FFF_FFFF;
    localparam logic [63:0] LIM_NEG_32 = 64'h0000_0000_8000_0000;
    localparam logic [63:0] LIM_POS_64 = 64'h7FFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] LIM_NEG_64 = 64'h8000_0000_0000_0000;
    localparam int unsigned RES_LATENCY = 1;

    typedef enum logic [1:0] {
        RM_NEAREST = 2'b00,
        RM_DOWN = 2'b01,
        RM_UP = 2'b10,
        RM_ZERO = 2'b11
    } ircu_rmode_e;

    typedef enum logic [2:0] {
        OP_I2R = 3'b000,
        OP_IL2R = 3'b001,
        OP_R2I = 3'b010,
        OP_R2IL = 3'b011,
        OP_RZ2I = 3'b100,
        OP_RZ2IL = 3'b101
    } ircu_op_e;

    typedef struct packed {
        logic valid;
        ircu_op_e op;
        logic tgt_single;
        logic [4:0] src_idx;
        logic [4:0] dst_idx;
        logic [63:0] int_src;
        logic [79:0] real_src;
    } ircu_req_s;

    typedef struct packed {
        ircu_rmode_e rmode;
        logic mask_inexact;
        logic mask_int_ovf;
    } ircu_ctrl_s;

    typedef struct packed {
        logic valid;
        logic fwe;
        logic [4:0] freg_idx;
        logic [79:0] freg_data;
        logic gwe_lo;
        logic gwe_hi;
        logic [4:0] greg_idx;
        logic [31:0] greg_lo;
        logic [31:0] greg_hi;
        logic exc_inexact;
        logic exc_int_ovf;
        logic pair_fault;
    } ircu_res_s;

    function automatic logic ircu_round_inc(ircu_rmode_e m, logic neg, logic lsb,
                                            logic g, logic st);
        logic inc;
        inc = 1'b0;
        case (m)
            RM_NEAREST: inc = g & (st | lsb);
            RM_DOWN: inc = neg & (g | st);
            RM_UP: inc = ~neg & (g | st);
            default: inc = 1'b0;
        endcase
        return inc;
    endfunction : ircu_round_inc

endpackage : ircu_pkg

// File: tb/ircu_core_model.sv
`timescale 1ns/1ns
module ircu_core_model (
    // Clock
    input wire logic core_clk,
    // Write-back from the unit
    input ircu_pkg::ircu_res_s res
);
    import ircu_pkg::*;
    logic [31:0] greg [32];
    logic [79:0] freg [32];
    always @(posedge core_clk) begin
        if (res.fwe) begin
            freg[res.freg_idx] <= res.freg_data;
        end
        if (res.gwe_lo) begin
            greg[res.greg_idx] <= res.greg_lo;
        end
        // High word lands in the next register of the pair
        if (res.gwe_hi) begin
            greg[res.greg_idx + 5'h1] <= res.greg_hi;
        end
    end
endmodule : ircu_core_model

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import ircu_pkg::*;
    logic core_clk;
    logic rst_b;
    ircu_req_s req;
    ircu_ctrl_s ctrl;
    ircu_res_s res;
    int mismatches;
    int checked;
    logic [31:0] pos_t [4] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0003, 32'h0000_0002};
    logic [31:0] neg_t [4] = '{32'hFFFF_FFFE, 32'hFFFF_FFFD, 32'hFFFF_FFFE, 32'hFFFF_FFFE};

    ircu_top dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .ctrl(ctrl), .res(res));
    ircu_core_model core (.core_clk(core_clk), .res(res));

    always #5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // One request; returns in the cycle its result stands
    task automatic issue(input ircu_op_e op, input logic ts, input logic [4:0] idx,
                         input logic [63:0] isrc, input logic [79:0] rsrc,
                         input ircu_rmode_e rm, input logic msk);
        req = '{1'b1, op, ts, idx, idx, isrc, rsrc};
        ctrl = '{rm, msk, msk};
        @(posedge core_clk);
        #1;
    endtask : issue

    task automatic t_int_to_real();
        issue(OP_I2R, 1'b0, 5'h03, 64'hFFFF_FFFF_FFFF_FFFF, '0, RM_NEAREST, 1'b0);
        check("i2r", res.freg_data, {1'b1, 15'h3FFF, 64'h8000_0000_0000_0000});
        check("i2r inx", res.exc_inexact, 1'b0);
        req.valid = 1'b0;
        @(posedge core_clk);
        #1;
        check("one cycle", res.valid, 1'b0);
        check("freg3", core.freg[3], {1'b1, 15'h3FFF, 64'h8000_0000_0000_0000});
        issue(OP_I2R, 1'b0, 5'h01, 64'h0000_0000_0100_0001, '0, RM_NEAREST, 1'b0);
        check("ext", res.freg_data, {1'b0, 15'h4017, 64'h8000_0080_0000_0000});
        check("ext inx", res.exc_inexact, 1'b0);
        issue(OP_I2R, 1'b1, 5'h01, 64'h0000_0000_0100_0001, '0, RM_NEAREST, 1'b0);
        check("sgl", res.freg_data, {1'b0, 15'h4017, 64'h8000_0000_0000_0000});
        check("sgl inx", res.exc_inexact, 1'b1);
        issue(OP_I2R, 1'b1, 5'h01, 64'h0000_0000_0100_0001, '0, RM_NEAREST, 1'b1);
        check("sgl masked", res.exc_inexact, 1'b0);
    endtask : t_int_to_real

    task automatic t_long_int();
        issue(OP_IL2R, 1'b0, 5'h05, 64'h0000_0001_0000_0000, '0, RM_NEAREST, 1'b0);
        check("odd src", {res.pair_fault, res.fwe}, 2'b10);
        issue(OP_IL2R, 1'b0, 5'h04, 64'h0000_0001_0000_0000, '0, RM_NEAREST, 1'b0);
        check("il2r", res.freg_data,
              {1'b0, 15'h401F, 64'h8000_0000_0000_0000});
    endtask : t_long_int

    task automatic t_round();
        for (int m = 0; m < 4; m++) begin
            issue(OP_R2I, 1'b0, 5'h02, '0, {1'b0, 15'h4000, 64'hA000_0000_0000_0000},
                  ircu_rmode_e'(m), 1'b0);
            check("r2i pos", res.greg_lo, pos_t[m]);
            check("r2i inx", res.exc_inexact, 1'b1);
            issue(OP_R2I, 1'b0, 5'h02, '0, {1'b1, 15'h4000, 64'hA000_0000_0000_0000},
                  ircu_rmode_e'(m), 1'b0);
            check("r2i neg", res.greg_lo, neg_t[m]);
            issue(OP_RZ2I, 1'b0, 5'h02, '0, {1'b1, 15'h4000, 64'hA000_0000_0000_0000},
                  ircu_rmode_e'(m), 1'b0);
            check("rz2i", {res.gwe_hi, res.greg_lo}, {1'b0, 32'hFFFF_FFFE});
        end
        issue(OP_R2I, 1'b0, 5'h02, '0, {1'b0, 15'h3FFE, 64'hC000_0000_0000_0000}, RM_UP, 1'b0);
        check("r2i up", res.greg_lo, 32'h0000_0001);
        issue(OP_RZ2I, 1'b0, 5'h02, '0, {1'b0, 15'h3FFF, 64'hC000_0000_0000_0000}, RM_UP, 1'b0);
        check("rz2i up", {res.exc_inexact, res.greg_lo}, 33'h1_0000_0001);
    endtask : t_round

    task automatic t_overflow();
        issue(OP_R2I, 1'b0, 5'h08, '0, {1'b0, 15'h401E, 64'h8000_0000_0000_0000}, RM_ZERO, 1'b0);
        check("ovf pos", {res.exc_int_ovf, res.greg_lo}, 33'h1_7FFF_FFFF);
        issue(OP_R2I, 1'b0, 5'h08, '0, {1'b1, 15'h401E, 64'h8000_0000_0000_0000}, RM_ZERO, 1'b0);
        check("neg edge", {res.exc_int_ovf, res.greg_lo}, {1'b0, 32'h8000_0000});
        issue(OP_R2I, 1'b0, 5'h08, '0, {1'b1, 15'h401F, 64'h8000_0000_0000_0000}, RM_ZERO, 1'b1);
        check("ovf masked", {res.exc_int_ovf, res.greg_lo}, 33'h0_8000_0000);
        issue(OP_R2I, 1'b0, 5'h08, '0, {1'b1, 15'h7FFF, 64'h8000_0000_0000_0000}, RM_UP, 1'b0);
        check("inf", {res.exc_int_ovf, res.greg_lo}, 33'h1_8000_0000);
    endtask : t_overflow

    task automatic t_long_res();
        issue(OP_R2IL, 1'b0, 5'h06, '0, {1'b0, 15'h401F, 64'h8000_0001_8000_0000}, RM_ZERO, 1'b0);
        check("r2il", {res.gwe_hi, res.greg_hi, res.greg_lo},
              {1'b1, 64'h1_0000_0003});
        req.valid = 1'b0;
        @(posedge core_clk);
        #1;
        check("pair", {core.greg[7], core.greg[6]}, 64'h0000_0001_0000_0003);
        issue(OP_RZ2IL, 1'b0, 5'h07, '0, {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000}, RM_ZERO, 1'b0);
        check("odd dst", {res.pair_fault, res.gwe_lo, res.gwe_hi}, 3'b100);
        issue(OP_RZ2IL, 1'b0, 5'h06, '0, {1'b0, 15'h403E, 64'h8000_0000_0000_0000}, RM_UP, 1'b0);
        check("ovf64", {res.exc_int_ovf, res.greg_hi, res.greg_lo},
              {1'b1, 64'h7FFF_FFFF_FFFF_FFFF});
    endtask : t_long_res

    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        ctrl = '0;
        mismatches = 0;
        checked = 0;
        repeat (10) @(posedge core_clk);
        #1;
        check("reset", res.valid, 1'b0);
        rst_b = 1'b1;
        t_int_to_real();
        t_long_int();
        t_round();
        t_overflow();
        t_long_res();
        tally_and_finish();
    end
endmodule : testbench
